// ==== shared/mam_defs.svh ====
// register offsets, field positions and reset values of the alert masking
// block; assumes an 8-bit register address bus inside the device
`ifndef MAM_DEFS_SVH
`define MAM_DEFS_SVH
`define MAM_ADDR_MASK_PRI 8'h74
`define MAM_ADDR_MASK_SEC 8'h75
`define MAM_ADDR_STAT_PRI 8'h41
`define MAM_ADDR_STAT_SEC 8'h42
`define MAM_BIT_SUMMARY 7
`define MAM_MASK_RESET 8'h00
`define MAM_STAT_RESET 8'h00
`define MAM_RDDATA_RESET 8'h00
`define MAM_PRI_SRC_COUNT 7
`define MAM_SEC_SRC_COUNT 8
`endif

// ==== shared/mam_pkg.sv ====
// types shared by the alert masking block
package mam_pkg;
  typedef logic [7:0] mam_byte_t;
endpackage : mam_pkg

// ==== core/mam_sync.sv ====
// three-stage synchroniser per bit for out-of-limit condition pins
// assumes inputs asynchronous to sys_clk
`timescale 1ns/1ps
`include "mam_defs.svh"
module mam_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // raw and settled levels
  input wire logic [WIDTH-1:0] rawIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] st1_r, st2_r, st3_r, out_r;
  logic [WIDTH-1:0] st1_nxt, st2_nxt, st3_nxt, out_nxt;
  genvar i;
  // a change counts only once stages two and three agree
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_comb begin
        out_nxt[i] = (st2_r[i] == st3_r[i]) ? st3_r[i] : out_r[i];
      end
    end
  endgenerate
  always_comb begin
    st1_nxt = rawIn;
    st2_nxt = st1_r;
    st3_nxt = st2_r;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st1_r <= '0;
      st2_r <= '0;
      st3_r <= '0;
      out_r <= '0;
    end else begin
      st1_r <= st1_nxt;
      st2_r <= st2_nxt;
      st3_r <= st3_nxt;
      out_r <= out_nxt;
    end
  end
  assign syncOut = out_r;
endmodule : mam_sync

// ==== core/mam_status.sv ====
// one sticky status byte: set by condition, cleared by a read once gone
// assumes rdStrobe is a one-cycle pulse on the same clock
`timescale 1ns/1ps
`include "mam_defs.svh"
module mam_status (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // condition levels and read strobe
  input wire logic [7:0] cond,
  input wire logic rdStrobe,
  // sticky flags
  output logic [7:0] sticky
);
  logic [7:0] stat_r, stat_nxt;
  // a live condition always wins over the read clear
  always_comb begin
    stat_nxt = stat_r | cond; // R12
    if (rdStrobe) begin
      stat_nxt = cond; // R12
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stat_r <= `MAM_STAT_RESET;
    end else begin
      stat_r <= stat_nxt;
    end
  end
  assign sticky = stat_r;
endmodule : mam_status

// ==== core/mam_alert_mask.sv ====
// alert masking of a system monitor: two sticky status bytes, two mask
// registers and the shared open-drain active-low alert output
// assumes a serial-bus slave elsewhere gives one-cycle read/write strobes
// with an 8-bit register address; condition inputs are asynchronous
//
// Functional notes
// R1: mask blocks alert only, status still sets
// R2: second mask acts only when summary bit set
// R3: mask bits 6..4 cover the temperature sources
// R4: mask bits 3..0 cover supply channels
// R5: second mask bits 7,6 cover diode faults
// R6: second mask bits 5..2 cover slow fans
// R7: second mask bit 1 covers overtemperature
// R8: second mask bit 0 covers 12 V
// R9: masks decoded at 0x74 and 0x75, read/write
// R10: host masks the source after reading status
// R11: host unmasks once status reads clear
// R12: status sticky until read with condition gone
// R13: alert held while out of limit, until read
// R14: first status bit 7 summarises second status
// R15: status bits align with mask bit positions
// R16: alert when any unmasked status bit set
// R17: masks reset to zero
`timescale 1ns/1ps
`include "mam_defs.svh"
module mam_alert_mask (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register access from the serial-bus slave
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regWrData,
  output mam_pkg::mam_byte_t regRdData,
  // out-of-limit conditions, first group bits 6..0 and second group 7..0
  input wire logic [6:0] condPrimary,
  input wire logic [7:0] condSecondary,
  // open-drain alert pin, active low
  output logic alertOut,
  output logic alertOe,
  // status views
  output mam_pkg::mam_byte_t statusPrimary,
  output mam_pkg::mam_byte_t statusSecondary
);
  logic [14:0] condSync;
  logic [7:0] stickyPri, stickySec;
  logic rdPri, rdSec;
  mam_pkg::mam_byte_t maskPri_r, maskPri_nxt;
  mam_pkg::mam_byte_t maskSec_r, maskSec_nxt;
  mam_pkg::mam_byte_t rdData_r, rdData_nxt;
  logic alert_r, alert_nxt;
  // source layout: first group in bits 6..0, second group in 14..7
  localparam int PRI_SRC_COUNT = `MAM_PRI_SRC_COUNT;
  localparam int SRC_COUNT = `MAM_PRI_SRC_COUNT + `MAM_SEC_SRC_COUNT;
  logic wrMaskPri, wrMaskSec;
  logic secondGroupSummary;
  // named views of the sticky sources
  logic remoteTwoTempFlag, localTempFlag, remoteOneTempFlag;
  logic fiveVoltFlag, deviceSupplyChannel, coreSupplyChannel;
  logic twoFiveVoltFlag;
  logic diodeTwoFault, diodeOneFault;
  logic fourthFanSlow, thirdFanSlow, secondFanSlow, firstFanSlow;
  logic overtempFlag, twelveVoltFlag;
  logic [SRC_COUNT-1:0] srcSticky, srcMaskRaw, srcMask, srcAlert;
  genvar s;

  mam_sync #(.WIDTH(15)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .rawIn({condSecondary, condPrimary}),
    .syncOut(condSync)
  );

  // status reads clear only the register read
  assign rdPri = regRdEn && (regAddr == `MAM_ADDR_STAT_PRI);
  assign rdSec = regRdEn && (regAddr == `MAM_ADDR_STAT_SEC);

  // bit 7 of the first byte is not a source; it is derived below
  mam_status u_stat_pri (
    .sys_clk(sys_clk),
    .rst(rst),
    .cond({1'b0, condSync[6:0]}), // R15
    .rdStrobe(rdPri),
    .sticky(stickyPri)
  );

  mam_status u_stat_sec (
    .sys_clk(sys_clk),
    .rst(rst),
    .cond(condSync[14:7]), // R15
    .rdStrobe(rdSec),
    .sticky(stickySec)
  );

  assign statusPrimary = {(|stickySec), stickyPri[6:0]}; // R14
  assign statusSecondary = stickySec;

  // write decode; writes to any other address are ignored here
  assign wrMaskPri = regWrEn && (regAddr == `MAM_ADDR_MASK_PRI); // R9
  assign wrMaskSec = regWrEn && (regAddr == `MAM_ADDR_MASK_SEC); // R9

  // mask register writes
  always_comb begin
    maskPri_nxt = maskPri_r;
    maskSec_nxt = maskSec_r;
    if (wrMaskPri) begin
      maskPri_nxt = regWrData; // R9
    end
    if (wrMaskSec) begin
      maskSec_nxt = regWrData; // R9
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      maskPri_r <= `MAM_MASK_RESET; // R17
      maskSec_r <= `MAM_MASK_RESET; // R17
    end else begin
      maskPri_r <= maskPri_nxt;
      maskSec_r <= maskSec_nxt;
    end
  end

  // read data held in a register; unknown addresses read zero
  always_comb begin
    rdData_nxt = rdData_r;
    if (regRdEn) begin
      case (regAddr)
        `MAM_ADDR_MASK_PRI: rdData_nxt = maskPri_r; // R9
        `MAM_ADDR_MASK_SEC: rdData_nxt = maskSec_r; // R9
        `MAM_ADDR_STAT_PRI: rdData_nxt = statusPrimary;
        `MAM_ADDR_STAT_SEC: rdData_nxt = statusSecondary;
        default: rdData_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdData_r <= `MAM_RDDATA_RESET;
    end else begin
      rdData_r <= rdData_nxt;
    end
  end

  // named sources; srcSticky keeps the mask bit order, so one index
  // names the same source in the status, mask and alert vectors
  assign twoFiveVoltFlag = stickyPri[0];
  assign coreSupplyChannel = stickyPri[1];
  assign deviceSupplyChannel = stickyPri[2];
  assign fiveVoltFlag = stickyPri[3];
  assign remoteOneTempFlag = stickyPri[4];
  assign localTempFlag = stickyPri[5];
  assign remoteTwoTempFlag = stickyPri[6];
  assign twelveVoltFlag = stickySec[0];
  assign overtempFlag = stickySec[1];
  assign firstFanSlow = stickySec[2];
  assign secondFanSlow = stickySec[3];
  assign thirdFanSlow = stickySec[4];
  assign fourthFanSlow = stickySec[5];
  assign diodeOneFault = stickySec[6];
  assign diodeTwoFault = stickySec[7];
  assign srcSticky = {diodeTwoFault, diodeOneFault, fourthFanSlow,
    thirdFanSlow, secondFanSlow, firstFanSlow, overtempFlag,
    twelveVoltFlag, remoteTwoTempFlag, localTempFlag, remoteOneTempFlag,
    fiveVoltFlag, deviceSupplyChannel, coreSupplyChannel,
    twoFiveVoltFlag}; // R15
  assign srcMaskRaw = {maskSec_r, maskPri_r[6:0]}; // R15
  // bit 7 of the first mask is a qualifier only, never a source mask
  assign secondGroupSummary = maskPri_r[`MAM_BIT_SUMMARY]; // R2

  // one gate per source: the first seven answer to the first mask, the
  // rest to the second mask, and that only behind the summary bit
  generate
    for (s = 0; s < SRC_COUNT; s++) begin : g_src
      if (s < PRI_SRC_COUNT) begin : g_pri
        // bits 6..4 temperatures, 3..0 supplies
        assign srcMask[s] = srcMaskRaw[s]; // R3 R4
      end else begin : g_sec
        // diodes, fans, overtemperature and 12 V, by position
        assign srcMask[s] = secondGroupSummary &&
          srcMaskRaw[s]; // R2 R5 R6 R7 R8
      end
      // the mask reaches only this gate; the sticky bit never sees it
      assign srcAlert[s] = srcSticky[s] && !srcMask[s]; // R1 R16
    end
  endgenerate

  // alert follows the sticky bits, so it outlasts the condition
  always_comb begin
    alert_nxt = |srcAlert; // R1 R13 R16
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      alert_r <= 1'h0;
    end else begin
      alert_r <= alert_nxt;
    end
  end

  assign regRdData = rdData_r;
  // open drain: pull low while alerting, release otherwise
  assign alertOut = 1'h0; // R16
  assign alertOe = alert_r; // R16
endmodule : mam_alert_mask

// ==== bench/mam_alert_mask_checker.sv ====
// port checker of the alert masking block
// assumes masks change only by writes at 0x74/0x75
`timescale 1ns/1ps
module mam_alert_mask_checker (
  input logic sys_clk,
  input logic rst,
  input logic [7:0] regAddr,
  input logic regWrEn,
  input logic regRdEn,
  input logic [7:0] regWrData,
  input mam_pkg::mam_byte_t regRdData,
  input logic [7:0] condSecondary,
  input logic alertOe,
  input mam_pkg::mam_byte_t statusPrimary,
  input mam_pkg::mam_byte_t statusSecondary
);
  logic [7:0] m1_r, m2_r;
  logic alertExp;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge sys_clk) begin
    if (rst) m1_r <= 8'h00;
    else if (regWrEn && regAddr == 8'h74) m1_r <= regWrData;
    if (rst) m2_r <= 8'h00;
    else if (regWrEn && regAddr == 8'h75) m2_r <= regWrData;
  end
  // second mask only counts behind the summary qualifier
  assign alertExp = (|(statusPrimary[6:0] & ~m1_r[6:0]))
    || (|(statusSecondary & ~(m1_r[7] ? m2_r : 8'h00)));
  sequence s_gone; (condSecondary == 8'h00) [*8]; endsequence
  sequence s_rd2; regRdEn && regAddr == 8'h42; endsequence
  property p_clear; s_gone ##0 s_rd2 |=> statusSecondary == 8'h00;
  endproperty
  property p_set; condSecondary[0] [*8] |-> statusSecondary[0]; endproperty
  property p_sticky;
    statusSecondary[1] && !(regRdEn && regAddr == 8'h42) |=>
      statusSecondary[1];
  endproperty
  property p_sum; statusPrimary[7] == |statusSecondary; endproperty
  property p_alert; 1'h1 |=> alertOe == $past(alertExp); endproperty
  property p_rdm; regRdEn && regAddr == 8'h75 |=> regRdData == $past(m2_r);
  endproperty
  property p_unm; regRdEn && regAddr == 8'h00 |=> regRdData == 8'h00;
  endproperty
  property p_hold; !regRdEn |=> $stable(regRdData); endproperty
  a_clear: assert property (p_clear) else $error("status not cleared");
  a_set: assert property (p_set) else $error("status not set");
  a_sticky: assert property (p_sticky) else $error("status lost");
  a_sum: assert property (p_sum) else $error("summary bit wrong");
  a_alert: assert property (p_alert) else $error("alert wrong");
  a_rdm: assert property (p_rdm) else $error("mask2 read wrong");
  a_unm: assert property (p_unm) else $error("unmapped read");
  a_hold: assert property (p_hold) else $error("read data moved");
endmodule : mam_alert_mask_checker
bind mam_alert_mask mam_alert_mask_checker i_chk (.sys_clk, .rst, .regAddr,
  .regWrEn, .regRdEn, .regWrData, .regRdData, .condSecondary, .alertOe,
  .statusPrimary, .statusSecondary);

// ==== bench/mam_host_model.sv ====
// host side of the open-drain alert line
// assumes a pull-up and a single driver
`timescale 1ns/1ps
module mam_host_model (
  input logic alertOut,
  input logic alertOe,
  output logic alertN
);
  // released line returns to the pull-up level
  assign alertN = alertOe ? alertOut : 1'h1;
endmodule : mam_host_model

// ==== bench/mam_alert_mask_tb.sv ====
// self-checking bench of the alert masking block
// assumes the bound checker and the host model
`timescale 1ns/1ps
module mam_alert_mask_tb;
  logic sys_clk, rst, regWrEn, regRdEn, alertOut, alertOe, alertN;
  logic [7:0] regAddr, regWrData, condSecondary;
  logic [6:0] condPrimary;
  mam_pkg::mam_byte_t regRdData, statusPrimary, statusSecondary, rdv;
  int error_cnt, check_count;
  // alert expected, mask1, mask2, cond1, cond2
  logic [32:0] rows [9] = '{33'h1_0000_4000, 33'h0_7f00_7f00,
    33'h1_00ff_0080, 33'h0_80ff_00ff, 33'h1_80fd_0002, 33'h1_7e00_0100,
    33'h0_80c0_00c0, 33'h0_803c_003c, 33'h1_80fe_0001};
  mam_alert_mask i_mam_alert_mask (.sys_clk, .rst, .regAddr, .regWrEn,
    .regRdEn, .regWrData, .regRdData, .condPrimary, .condSecondary,
    .alertOut, .alertOe, .statusPrimary, .statusSecondary);
  mam_host_model i_mam_host_model (.alertOut, .alertOe, .alertN);
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = w;
    regRdEn = !w;
    @(negedge sys_clk);
    rdv = regRdData;
    regWrEn = 1'h0;
    regRdEn = 1'h0;
    // idle cycle: a following call never reassigns a strobe in this step
    @(negedge sys_clk);
  endtask : acc
  task automatic results();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    {rst, regWrEn, regRdEn, regAddr, regWrData} = {1'h1, 18'h0};
    {condPrimary, condSecondary} = 15'h0;
    repeat (10) @(negedge sys_clk);
    rst = 1'h0;
    acc(1'h0, 8'h74, 8'h00);
    chk("mask1", rdv, 8'h00);
    acc(1'h0, 8'h75, 8'h00);
    chk("mask2", rdv, 8'h00);
    acc(1'h1, 8'h75, 8'h5a);
    acc(1'h0, 8'h75, 8'h00);
    chk("mask2", rdv, 8'h5a);
    acc(1'h0, 8'h00, 8'h00);
    chk("unmapped", rdv, 8'h00);
    foreach (rows[i]) begin
      acc(1'h1, 8'h74, rows[i][31:24]);
      acc(1'h1, 8'h75, rows[i][23:16]);
      {condPrimary, condSecondary} = {rows[i][14:8], rows[i][7:0]};
      repeat (10) @(negedge sys_clk);
      chk("alert", alertOe, rows[i][32]);
      chk("pin", alertN, !rows[i][32]);
      chk("od level", alertOut, 8'h00);
      chk("stat1", statusPrimary, {|rows[i][7:0], rows[i][14:8]});
      chk("stat2", statusSecondary, rows[i][7:0]);
      {condPrimary, condSecondary} = 15'h0;
      repeat (10) @(negedge sys_clk);
      chk("alert held", alertOe, rows[i][32]);
      acc(1'h0, 8'h41, 8'h00);
      acc(1'h0, 8'h42, 8'h00);
      repeat (3) @(negedge sys_clk);
      chk("clear", statusPrimary | statusSecondary | alertOe, 8'h00);
    end
    acc(1'h1, 8'h74, 8'h00);
    condPrimary = 7'h20;
    for (int n = 0; n < 20 && alertOe !== 1'h1; n++) @(negedge sys_clk);
    chk("raised", alertOe, 1'h1);
    if (alertOe !== 1'h1) results();
    acc(1'h0, 8'h41, 8'h00);
    chk("source", rdv, 8'h20);
    acc(1'h1, 8'h74, 8'h20);
    repeat (3) @(negedge sys_clk);
    chk("masked", alertOe, 1'h0);
    chk("kept", statusPrimary, 8'h20);
    condPrimary = 7'h00;
    repeat (10) @(negedge sys_clk);
    acc(1'h0, 8'h41, 8'h00);
    @(negedge sys_clk);
    chk("polled", statusPrimary, 8'h00);
    acc(1'h1, 8'h74, 8'h00);
    repeat (3) @(negedge sys_clk);
    chk("unmasked", alertOe, 1'h0);
    results();
  end
endmodule : mam_alert_mask_tb
